//--- hw/rds_pkg.sv
// shared constants and types of the receive deskew and status block
package rds_pkg;
  // ==========================================================
  // link and frame layout
  localparam int LANES = 16;
  localparam int WORD_W = 16;
  localparam int FRAME_WORDS = 68;
  localparam int SAMPLE_FIRST = 4;
  localparam int SAMPLE_PER_LANE = 4;
  localparam int FRM_CHECK_POS = 1;
  localparam logic [15:0] FRM_WORD_A = 16'hf6f6;
  localparam logic [15:0] FRM_WORD_B = 16'h2828;
  localparam logic [15:0] HDR_WORD = 16'haaaa;
  localparam logic [6:0] POS_LAST = 7'h43;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STS = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0] ADDR_LANE_LOCK = 8'h10;
  localparam int CTRL_LOCK_LSB = 0;
  localparam int CTRL_UNLOCK_LSB = 8;
  localparam int CTRL_ALLOW_LSB = 16;
  localparam int STS_LOF_BIT = 0;
  localparam int STS_STATE_LSB = 4;
  localparam int STS_DLY_LSB = 8;
  localparam int CNT_W = 7;
  localparam logic [6:0] CNT_RST = 7'h04;
  localparam logic [6:0] CNT_MAX = 7'h40;
  localparam int INT_FERR = 0;
  localparam int INT_LOF = 1;
  localparam int INT_MISM = 2;
  localparam int INT_W = 3;
  // ==========================================================
  // framer states
  typedef enum logic [1:0] {
    ST_SEARCH,
    ST_CONFIRM,
    ST_LOCK
  } rds_state_e;
endpackage

//--- hw/rds_rx_deskew.sv
// receive deskew framer, lane aligner and status registers
`timescale 1ns/1ps

// Behaviour
// - one mismatch bit per data lane
// - mismatch bit is high one cycle per mismatching sample word, up to four in a row
// - frame error on framing pattern difference
// - frame error is a one-cycle pulse
// - loss of frame high while framing lost
// - output the bit-aligned deskew word
// - delay value per lane and deskew
// - frame: F6F6 2828, two headers, samples
// - search steps deskew delay one bit
// - lock/unlock after configurable frame counts
// - lane re-searches after configurable bad frames
module rds_rx_deskew
  import rds_pkg::*;
#(
  parameter int NUM_LANES = LANES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [15:0] lane_receive_word_i [NUM_LANES],
  input wire logic [15:0] deskew_word_i,
  output logic [15:0] aligned_deskew_o,
  output logic [15:0] channel_delay_value_o [NUM_LANES],
  output logic [15:0] deskew_delay_o,
  output logic [NUM_LANES-1:0] mismatch_o,
  output logic lof_o,
  output logic frm_err_o
);

  // the sample slots of one frame must hold exactly four words per lane
  if (NUM_LANES * SAMPLE_PER_LANE + SAMPLE_FIRST != FRAME_WORDS) begin
    $error("NUM_LANES does not fit the frame sample layout");
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] sel_word(logic [31:0] w,
                                           logic [3:0] off);
    return w[off +: 16];
  endfunction

  // a field written outside 1..64 keeps its old value
  function automatic logic [6:0] fit_cnt(logic [7:0] v,
                                         logic [6:0] old);
    if (v == 8'h00 || v > {1'b0, CNT_MAX}) begin
      return old;
    end
    return v[6:0];
  endfunction

  // ==========================================================
  // deskew channel framer
  rds_state_e st_q;
  logic [15:0] dsc_prev_q;
  logic [15:0] dsc_al;
  logic [15:0] al_q;
  logic [3:0] dsc_off_q;
  logic [6:0] pos_q;
  logic [6:0] good_q;
  logic [6:0] miss_q;
  logic lof_q;
  logic ferr_q;
  logic [6:0] lock_n_q;
  logic [6:0] unlock_n_q;
  logic [6:0] allow_n_q;
  logic pat_ok;
  logic chk_pos;
  logic frame_end;

  assign dsc_al = sel_word({dsc_prev_q, deskew_word_i}, dsc_off_q);
  assign pat_ok = (al_q == FRM_WORD_A) && (dsc_al == FRM_WORD_B);
  assign chk_pos = (pos_q == 7'(FRM_CHECK_POS));
  assign frame_end = (pos_q == POS_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsc_prev_q <= 16'h0000;
      al_q <= 16'h0000;
    end else begin
      dsc_prev_q <= deskew_word_i;
      al_q <= dsc_al;
    end
  end

  // pos_q is the frame position of the word in dsc_al this cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 7'h00;
    end else if (st_q == ST_SEARCH && pat_ok) begin
      pos_q <= 7'(FRM_CHECK_POS + 1);
    end else if (frame_end) begin
      pos_q <= 7'h00;
    end else begin
      pos_q <= pos_q + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_SEARCH;
      dsc_off_q <= 4'h0;
      good_q <= 7'h00;
      miss_q <= 7'h00;
      lof_q <= 1'b1;
      ferr_q <= 1'b0;
    end else begin
      ferr_q <= 1'b0;
      case (st_q)
        ST_SEARCH: begin
          if (pat_ok) begin
            good_q <= 7'h01;
            if (lock_n_q == 7'h01) begin
              st_q <= ST_LOCK;
              lof_q <= 1'b0;
              miss_q <= 7'h00;
            end else begin
              st_q <= ST_CONFIRM;
            end
          end else if (frame_end) begin
            // a whole frame passed without the pattern at this offset
            dsc_off_q <= dsc_off_q + 4'h1;
          end
        end
        ST_CONFIRM: begin
          if (chk_pos && pat_ok) begin
            good_q <= good_q + 7'h01;
            if (good_q + 7'h01 >= lock_n_q) begin
              st_q <= ST_LOCK;
              lof_q <= 1'b0;
              miss_q <= 7'h00;
            end
          end else if (chk_pos) begin
            ferr_q <= 1'b1;
            st_q <= ST_SEARCH;
          end
        end
        ST_LOCK: begin
          if (chk_pos && pat_ok) begin
            miss_q <= 7'h00;
          end else if (chk_pos) begin
            ferr_q <= 1'b1;
            miss_q <= miss_q + 7'h01;
            if (miss_q + 7'h01 >= unlock_n_q) begin
              st_q <= ST_SEARCH;
              lof_q <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= ST_SEARCH;
          lof_q <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // data lane alignment against the deskew samples
  logic [15:0] ch_prev_q [NUM_LANES];
  logic [15:0] ch_al [NUM_LANES];
  logic [3:0] ch_off_q [NUM_LANES];
  logic [6:0] ch_bad_q [NUM_LANES];
  logic [NUM_LANES-1:0] ch_lock_q;
  logic [NUM_LANES-1:0] ch_hit_q;
  logic [NUM_LANES-1:0] mism_d;
  logic [NUM_LANES-1:0] mism_q;
  logic [6:0] rel_pos;
  logic in_smp;

  assign rel_pos = pos_q - 7'(SAMPLE_FIRST);
  assign in_smp = (pos_q >= 7'(SAMPLE_FIRST));

  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      ch_al[i] = sel_word({ch_prev_q[i], lane_receive_word_i[i]},
                          ch_off_q[i]);
      mism_d[i] = (st_q == ST_LOCK) && in_smp &&
                  (rel_pos[5:2] == 4'(i)) && (ch_al[i] != dsc_al);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mism_q <= '0;
    end else begin
      mism_q <= mism_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_lock_q <= '0;
      ch_hit_q <= '0;
      for (int i = 0; i < NUM_LANES; i++) begin
        ch_prev_q[i] <= 16'h0000;
        ch_off_q[i] <= 4'h0;
        ch_bad_q[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < NUM_LANES; i++) begin
        ch_prev_q[i] <= lane_receive_word_i[i];
        if (st_q != ST_LOCK) begin
          // samples mean nothing without frame, so start over later
          ch_lock_q[i] <= 1'b0;
          ch_hit_q[i] <= 1'b0;
          ch_bad_q[i] <= 7'h00;
        end else if (frame_end) begin
          ch_hit_q[i] <= 1'b0;
          if (!ch_lock_q[i]) begin
            if (ch_hit_q[i] | mism_d[i]) begin
              ch_off_q[i] <= ch_off_q[i] + 4'h1;
            end else begin
              ch_lock_q[i] <= 1'b1;
            end
          end else if (ch_hit_q[i] | mism_d[i]) begin
            if (ch_bad_q[i] + 7'h01 >= allow_n_q) begin
              ch_lock_q[i] <= 1'b0;
              ch_off_q[i] <= ch_off_q[i] + 4'h1;
              ch_bad_q[i] <= 7'h00;
            end else begin
              ch_bad_q[i] <= ch_bad_q[i] + 7'h01;
            end
          end else begin
            ch_bad_q[i] <= 7'h00;
          end
        end else if (mism_d[i]) begin
          ch_hit_q[i] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      channel_delay_value_o[i] = {12'h000, ch_off_q[i]};
    end
  end
  assign deskew_delay_o = {12'h000, dsc_off_q};
  assign aligned_deskew_o = al_q;
  assign mismatch_o = mism_q;
  assign lof_o = lof_q;
  assign frm_err_o = ferr_q;

  // ==========================================================
  // registers and interrupt
  logic [INT_W-1:0] int_sts_q;
  logic [INT_W-1:0] int_mask_q;
  logic [INT_W-1:0] int_ev;
  logic [31:0] rd_d;
  logic ack_q;
  logic lof_dly_q;
  logic wr_en;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign int_ev = {|mism_q, lof_q && !lof_dly_q, ferr_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_n_q <= CNT_RST;
      unlock_n_q <= CNT_RST;
      allow_n_q <= CNT_RST;
      int_mask_q <= '0;
    end else if (wr_en && wb_adr_i == ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        lock_n_q <= fit_cnt(wb_dat_i[CTRL_LOCK_LSB +: 8], lock_n_q);
      end
      if (wb_sel_i[1]) begin
        unlock_n_q <= fit_cnt(wb_dat_i[CTRL_UNLOCK_LSB +: 8],
                              unlock_n_q);
      end
      if (wb_sel_i[2]) begin
        allow_n_q <= fit_cnt(wb_dat_i[CTRL_ALLOW_LSB +: 8], allow_n_q);
      end
    end else if (wr_en && wb_adr_i == ADDR_INT_MASK && wb_sel_i[0]) begin
      int_mask_q <= wb_dat_i[INT_W-1:0];
    end
  end

  // a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_sts_q <= '0;
      lof_dly_q <= 1'b1;
    end else begin
      lof_dly_q <= lof_q;
      if (wr_en && wb_adr_i == ADDR_INT_STS && wb_sel_i[0]) begin
        int_sts_q <= (int_sts_q & ~wb_dat_i[INT_W-1:0]) | int_ev;
      end else begin
        int_sts_q <= int_sts_q | int_ev;
      end
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_CTRL: begin
        rd_d[CTRL_LOCK_LSB +: CNT_W] = lock_n_q;
        rd_d[CTRL_UNLOCK_LSB +: CNT_W] = unlock_n_q;
        rd_d[CTRL_ALLOW_LSB +: CNT_W] = allow_n_q;
      end
      ADDR_STATUS: begin
        rd_d[STS_LOF_BIT] = lof_q;
        rd_d[STS_STATE_LSB +: 2] = st_q;
        rd_d[STS_DLY_LSB +: 4] = dsc_off_q;
      end
      ADDR_INT_STS: rd_d[INT_W-1:0] = int_sts_q;
      ADDR_INT_MASK: rd_d[INT_W-1:0] = int_mask_q;
      ADDR_LANE_LOCK: rd_d[NUM_LANES-1:0] = ch_lock_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // every access, mapped or not, is answered one edge after it starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign irq_o = |(int_sts_q & int_mask_q);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_mism_cause: assert property (
    |mismatch_o |-> $past(st_q) == ST_LOCK && $past(in_smp))
    else $error("mismatch pulse outside a locked sample slot");
  chk_mism_slot: assert property (
    mismatch_o != '0 |-> $onehot(mismatch_o))
    else $error("mismatch seen on more than one lane at once");
  chk_ferr_pos: assert property (
    frm_err_o |-> $past(chk_pos) && !$past(pat_ok))
    else $error("frame error without a bad framing check");
  chk_ferr_pulse: assert property (
    frm_err_o |=> !frm_err_o ##1 !frm_err_o)
    else $error("frame error held longer than one cycle");
  chk_lof_state: assert property (
    lof_o == (st_q != ST_LOCK))
    else $error("loss of frame disagrees with framer state");
  chk_search_step: assert property (
    st_q == ST_SEARCH && frame_end && !pat_ok
    |=> dsc_off_q == $past(dsc_off_q) + 4'h1)
    else $error("search did not advance the delay by one bit");
  chk_lock_count: assert property (
    st_q == ST_CONFIRM ##1 st_q == ST_LOCK
    |-> $past(good_q) + 7'h01 >= lock_n_q)
    else $error("framer locked before enough good frames");
  chk_dly_out: assert property (
    deskew_delay_o[3:0] == dsc_off_q && deskew_delay_o[15:4] == 12'h000)
    else $error("deskew delay output wrong");
  chk_rst_lof: assert property (
    @(posedge clk_i) disable iff (1'b0) $past(rst_i) |-> lof_o)
    else $error("loss of frame not shown after reset");
  chk_wb_ack: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held two cycles");
endmodule

//--- bench/rds_serdes_model.sv
// far-side serdes model: framed deskew channel and random data lanes
`timescale 1ns/1ps
// ==========================================================
// receiver model
module rds_serdes_model #(
  parameter int SHIFT = 13
) (
  input wire logic clk_i,
  input wire logic bad_frm_i,
  input wire logic bad_mis_i,
  input wire logic [3:0] bad_lane_i,
  output logic [15:0] lane_o [16],
  output logic [15:0] dsk_o,
  output logic [6:0] pos_o
);
  logic [31:0] rnd = 32'hdf37;
  logic [15:0] w [16];
  logic [15:0] pw [17] = '{default: 16'h0};
  logic [15:0] d;
  logic [31:0] cat;
  logic [6:0] p;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  initial begin
    pos_o = 7'd67;
    dsk_o = 16'h0;
    foreach (lane_o[i]) lane_o[i] = 16'h0;
  end
  // every lane shifts by the same bit count, so one offset fits all
  always @(posedge clk_i) begin
    p = (pos_o == 7'd67) ? 7'd0 : pos_o + 7'd1;
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      w[i] = rnd[15:0];
    end
    case (p)
      7'd0: d = 16'hf6f6 ^ {15'h0, bad_frm_i};
      7'd1: d = 16'h2828;
      7'd2, 7'd3: d = 16'haaaa;
      default: d = w[(p - 7'd4) >> 2];
    endcase
    // the lane word is flipped after its sample was copied
    if (bad_mis_i && p == 7'd4 + {1'b0, bad_lane_i, 2'b00}) begin
      w[bad_lane_i] = w[bad_lane_i] ^ 16'h0001;
    end
    for (int i = 0; i < 17; i++) begin
      cat = {pw[i], (i == 16) ? d : w[i]} >> SHIFT;
      pw[i] = (i == 16) ? d : w[i];
      if (i == 16) dsk_o <= cat[15:0];
      else lane_o[i] <= cat[15:0];
    end
    pos_o <= p;
  end
endmodule

//--- bench/rds_rx_deskew_tb_top.sv
// self-checking bench of the receive deskew block
`timescale 1ns/1ps
module rds_rx_deskew_tb_top
  import rds_pkg::*;
;
  localparam int SHIFT = 13;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat;
  logic ack, irq, lof, ferr, armed = 0;
  logic [15:0] lanes [16];
  logic [15:0] dly [16];
  logic [15:0] dsk, aligned, ddly, mism, prev;
  logic bad_frm = 0, bad_mis = 0;
  logic [3:0] bad_lane = 0;
  logic [6:0] pos;
  logic [31:0] rd_q [$];
  logic [16:0] ev_q [$];
  logic [16:0] ev_e;
  logic [31:0] rd_e;
  int failures = 0, total_checks = 0, k;
  always #2 clk_i = ~clk_i;
  rds_rx_deskew #(.NUM_LANES(16)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .lane_receive_word_i(lanes), .deskew_word_i(dsk),
    .aligned_deskew_o(aligned), .channel_delay_value_o(dly),
    .deskew_delay_o(ddly), .mismatch_o(mism), .lof_o(lof),
    .frm_err_o(ferr));
  rds_serdes_model #(.SHIFT(SHIFT)) far (.clk_i(clk_i),
    .bad_frm_i(bad_frm), .bad_mis_i(bad_mis), .bad_lane_i(bad_lane),
    .lane_o(lanes), .dsk_o(dsk), .pos_o(pos));
  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // drivers
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(0, a, 32'h0);
  endtask
  task automatic wait_pos;
    do @(posedge clk_i); while (pos !== 7'd30);
  endtask
  // corruption is switched mid-frame so whole frames are hit
  task automatic frames(input int n, input logic f, input logic m,
                        input logic [3:0] l);
    wait_pos;
    bad_frm <= f;
    bad_mis <= m;
    bad_lane <= l;
    repeat (n) wait_pos;
    bad_frm <= 0;
    bad_mis <= 0;
  endtask
  // ==========================================================
  // result watcher: oldest note against each result
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      rd_e = rd_q.size() ? rd_q.pop_front() : 32'hdead0000;
      chk(rdat, rd_e);
    end
    if (armed && (mism !== 16'h0 || ferr !== 1'b0)) begin
      ev_e = ev_q.size() ? ev_q.pop_front() : 17'h1ffff;
      chk({15'h0, mism, ferr}, {15'h0, ev_e});
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    chk({irq, ferr, lof, mism}, {3'b001, 16'h0});
    rd(ADDR_CTRL, 32'h00040404);
    rd(ADDR_INT_MASK, 32'h0);
    rd(ADDR_STATUS, 32'h1);
    wb(1, 8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    wb(1, ADDR_CTRL, 32'h00414141);
    rd(ADDR_CTRL, 32'h00040404);
    repeat (16) wait_pos;
    rd(ADDR_STATUS, 32'((16 - SHIFT) << 8) | 32'h20);
    rd(ADDR_LANE_LOCK, 32'hffff);
    chk(ddly, 32'(16 - SHIFT));
    foreach (dly[i]) chk(dly[i], 32'(16 - SHIFT));
    chk(lof, 0);
    // exactly one frame of back-to-back pairs, so the pattern shows once
    k = 0;
    prev = aligned;
    repeat (68) begin
      @(posedge clk_i);
      if (prev === FRM_WORD_A && aligned === FRM_WORD_B) k++;
      prev = aligned;
    end
    chk(k, 1);
    armed <= 1;
    wb(1, ADDR_INT_STS, 32'h7);
    rd(ADDR_INT_STS, 32'h0);
    for (int l = 0; l < 16; l += 15) begin
      ev_q.push_back({16'(1) << l, 1'b0});
      frames(1, 0, 1, 4'(l));
    end
    chk(dly[15], 32'(16 - SHIFT));
    rd(ADDR_INT_STS, 32'h4);
    @(posedge clk_i);
    chk(irq, 0);
    wb(1, ADDR_INT_MASK, 32'h4);
    @(posedge clk_i);
    chk(irq, 1);
    wb(1, ADDR_INT_STS, 32'h4);
    @(posedge clk_i);
    chk(irq, 0);
    ev_q.push_back(17'h1);
    frames(1, 1, 0, 4'h0);
    chk(lof, 0);
    rd(ADDR_INT_STS, 32'h1);
    repeat (4) ev_q.push_back(17'h1);
    frames(4, 1, 0, 4'h0);
    chk(lof, 1);
    rd(ADDR_INT_STS, 32'h3);
    wb(1, ADDR_INT_MASK, 32'h2);
    @(posedge clk_i);
    chk(irq, 1);
    chk(ev_q.size(), 0);
    tally_and_finish;
  end
endmodule
